// ---- pkg/vid_out_pkg.sv ----
// Package: register map, field layout, reset values and timing for the video output config block
package vid_out_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] VIDEO_STANDARD_SELECT_ADDR    = 8'h00;
  localparam logic [7:0] PRIMARY_MODE_SELECT_ADDR      = 8'h01;
  localparam logic [7:0] CRYSTAL_FREQUENCY_CONFIG_ADDR = 8'h04;
  localparam logic [7:0] FIELD_ON_ENABLE_PIN_ADDR      = 8'h05;
  localparam logic [7:0] SYNC_POLARITY_AND_SELECT_ADDR = 8'h06;
  localparam logic [7:0] OUTPUT_DRIVE_STRENGTH_ADDR    = 8'h14;
  localparam logic [7:0] MAIN_RESET_ADDR               = 8'hFF;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MAIN_RESET_BIT      = 7;
  localparam int VERT_SRC_BIT        = 7;
  localparam int FIELD_ON_EN_BIT     = 4;
  localparam int CLK_INV_BIT         = 0;
  localparam int HS_POL_BIT          = 1;
  localparam int VS_POL_BIT          = 2;
  localparam int FE_POL_BIT          = 3;
  localparam int XTAL_LSB            = 1;
  localparam int CLK_DRV_LSB         = 2;
  localparam int SYNC_DRV_LSB        = 0;

  // ---------------------------------------------------------------
  // Codes and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] DRIVE_RESERVED    = 2'h0;
  localparam logic [1:0] DRIVE_MED_HIGH    = 2'h2;
  localparam logic [1:0] XTAL_RESET        = 2'h1;
  localparam logic [3:0] MODE_COMPONENT    = 4'h5;
  localparam logic [3:0] MODE_GRAPHICS     = 4'h6;
  localparam logic [5:0] VIDEO_STANDARD_CODE_RESET     = 6'h02;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ            = 25_000_000;
  localparam int AUDIO_LOCK_US     = 5000;
  localparam int AUDIO_LOCK_CYCLES = (CLK_HZ / 1_000_000) * AUDIO_LOCK_US;

  typedef struct packed {
    logic [5:0] video_standard_code;
    logic [3:0] primary_mode_code;
    logic [1:0] crystal_frequency_select;
    logic       field_on_enable;
    logic       vertical_pin_source_select;
    logic       field_enable_polarity;
    logic       vsync_polarity;
    logic       hsync_polarity;
    logic       pixel_clock_invert;
    logic [1:0] clock_pin_drive_level;
    logic [1:0] sync_pin_drive_level;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{
    video_standard_code:        VIDEO_STANDARD_CODE_RESET,
    primary_mode_code:          MODE_GRAPHICS,
    crystal_frequency_select:   XTAL_RESET,
    field_on_enable:            1'b0,
    vertical_pin_source_select: 1'b1,
    field_enable_polarity:      1'b0,
    vsync_polarity:             1'b0,
    hsync_polarity:             1'b0,
    pixel_clock_invert:         1'b0,
    clock_pin_drive_level:      DRIVE_MED_HIGH,
    sync_pin_drive_level:       DRIVE_MED_HIGH
  };

  // Raw timing markers from the decoder, all active high
  typedef struct packed {
    logic hsync;
    logic vsync;
    logic field;
    logic data_enable;
  } timing_t;

endpackage

// ---- verilog/video_output_sync_config.sv ----
// Video output sync steering, polarity, drive settings and clock synthesizer status
// Operation
// - Clock and sync drive fields, reset medium-high
// - Sync drive covers hsync, vsync/field, enable
// - Vertical pin: 0 field, 1 vsync
// - Enable pin: 0 data enable, 1 field
// - Clock invert affects only pixel clock pin
// - Hsync polarity: 0 low, 1 high
// - Vertical pin polarity: 0 low, 1 high
// - Field/enable polarity: 1 inverts to low
// - Regenerated pixel clock, optionally divided, drives pin
// - Video synthesizer locks within one frame
// - Audio clock is link clock times N/CTS
// - Audio synthesizer locks within 5 ms
// - Crystal select, reset 28.63636 MHz
// - Mode 0101 component, 0110 graphics, else reserved
// - Video standard reset 000010, mode dependent
// - Receive modes route video and audio onward
// - Decode any resolution; settings steer processing
// - Self-clearing main reset restores all registers
`timescale 1ns/1ns
`default_nettype none
module video_output_sync_config
  import vid_out_pkg::*;
#(
  parameter int AUDIO_LOCK_LIMIT = AUDIO_LOCK_CYCLES,
  parameter int FRAME_CYCLES     = 1_000_000,
  parameter int CTR_W            = 24
) (
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output var  logic [7:0] REG_RDATA,
  input  wire timing_t    TIMING_IN,
  input  wire logic       PIXEL_CLK_SRC,
  input  wire logic       PIXEL_CLK_DIV_SEL,
  input  wire logic       PIXEL_CLK_DIV_SRC,
  input  wire logic       VIDEO_PLL_LOCKED_RAW,
  input  wire logic       AUDIO_REGEN_PKT,
  input  wire logic       AUDIO_PLL_LOCKED_RAW,
  input  wire logic       VIDEO_FRAME_START,
  output var  logic       HORIZONTAL_SYNC_OUT,
  output var  logic       VERTICAL_FIELD_PIN,
  output var  logic       DATA_ENABLE_OUT,
  output var  logic       OUTPUT_PIXEL_CLOCK,
  output var  logic [1:0] CLOCK_PIN_DRIVE_LEVEL,
  output var  logic [1:0] SYNC_PIN_DRIVE_LEVEL,
  output var  logic [1:0] CRYSTAL_FREQUENCY_SELECT,
  output var  logic [3:0] PRIMARY_MODE_CODE,
  output var  logic [5:0] VIDEO_STANDARD_CODE,
  output var  logic       COMPONENT_MODE,
  output var  logic       GRAPHICS_MODE,
  output var  logic       ROUTE_TO_COMPONENT_PROCESSOR,
  output var  logic       VIDEO_LOCKED,
  output var  logic       AUDIO_LOCKED,
  output var  logic       VIDEO_LOCK_LATE,
  output var  logic       AUDIO_LOCK_LATE
);

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  cfg_t cfg_q;
  logic main_reset_wr;

  assign main_reset_wr = REG_WR && (REG_ADDR == MAIN_RESET_ADDR) && REG_WDATA[MAIN_RESET_BIT];

  // The main reset bit is never stored, so it always reads back zero
  always_ff @(posedge CLK) begin
    if (SYS_RST || main_reset_wr) begin
      cfg_q <= CFG_RESET;
    end else if (REG_WR) begin
      unique case (REG_ADDR)
        VIDEO_STANDARD_SELECT_ADDR: begin
          cfg_q.video_standard_code <= REG_WDATA[5:0];
        end
        PRIMARY_MODE_SELECT_ADDR: begin
          cfg_q.primary_mode_code <= REG_WDATA[3:0];
        end
        CRYSTAL_FREQUENCY_CONFIG_ADDR: begin
          cfg_q.crystal_frequency_select <= REG_WDATA[XTAL_LSB+:2];
        end
        FIELD_ON_ENABLE_PIN_ADDR: begin
          cfg_q.field_on_enable <= REG_WDATA[FIELD_ON_EN_BIT];
        end
        SYNC_POLARITY_AND_SELECT_ADDR: begin
          cfg_q.vertical_pin_source_select <= REG_WDATA[VERT_SRC_BIT];
          cfg_q.field_enable_polarity      <= REG_WDATA[FE_POL_BIT];
          cfg_q.vsync_polarity             <= REG_WDATA[VS_POL_BIT];
          cfg_q.hsync_polarity             <= REG_WDATA[HS_POL_BIT];
          cfg_q.pixel_clock_invert         <= REG_WDATA[CLK_INV_BIT];
        end
        OUTPUT_DRIVE_STRENGTH_ADDR: begin
          cfg_q.clock_pin_drive_level <= REG_WDATA[CLK_DRV_LSB+:2];
          cfg_q.sync_pin_drive_level  <= REG_WDATA[SYNC_DRV_LSB+:2];
        end
        default: begin
        end
      endcase
    end
  end

  logic [7:0] rdata_d;
  always_comb begin
    rdata_d = 8'h00;
    unique case (REG_ADDR)
      VIDEO_STANDARD_SELECT_ADDR:    rdata_d = {2'b00, cfg_q.video_standard_code};
      PRIMARY_MODE_SELECT_ADDR:      rdata_d = {4'h0, cfg_q.primary_mode_code};
      CRYSTAL_FREQUENCY_CONFIG_ADDR: rdata_d = {5'h00, cfg_q.crystal_frequency_select, 1'b0};
      FIELD_ON_ENABLE_PIN_ADDR:      rdata_d = {3'b000, cfg_q.field_on_enable, 4'h0};
      SYNC_POLARITY_AND_SELECT_ADDR: rdata_d = {cfg_q.vertical_pin_source_select, 3'b000,
                                                cfg_q.field_enable_polarity, cfg_q.vsync_polarity,
                                                cfg_q.hsync_polarity, cfg_q.pixel_clock_invert};
      OUTPUT_DRIVE_STRENGTH_ADDR:    rdata_d = {4'h0, cfg_q.clock_pin_drive_level,
                                                cfg_q.sync_pin_drive_level};
      default:                       rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Sync steering and polarity
  // ---------------------------------------------------------------
  // Raw markers are active high; a polarity bit of 0 means active low for
  // hsync and the vertical pin, but active high for field and enable.
  logic vert_src;
  logic en_src;
  logic field_adj;
  logic en_adj;

  assign field_adj = TIMING_IN.field ^ cfg_q.field_enable_polarity;
  assign en_adj    = TIMING_IN.data_enable ^ cfg_q.field_enable_polarity;
  assign vert_src  = cfg_q.vertical_pin_source_select ? TIMING_IN.vsync : TIMING_IN.field;
  assign en_src    = cfg_q.field_on_enable ? field_adj : en_adj;

  // Registered outputs: a setting change lands on the pins one cycle later
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      HORIZONTAL_SYNC_OUT <= 1'b1;
      VERTICAL_FIELD_PIN  <= 1'b1;
      DATA_ENABLE_OUT     <= 1'b0;
    end else begin
      HORIZONTAL_SYNC_OUT <= TIMING_IN.hsync ^ ~cfg_q.hsync_polarity;
      VERTICAL_FIELD_PIN  <= vert_src ^ ~cfg_q.vsync_polarity;
      DATA_ENABLE_OUT     <= en_src;
    end
  end

  // ---------------------------------------------------------------
  // Pixel clock output
  // ---------------------------------------------------------------
  // The inversion bit is retimed and only swapped while the source is low,
  // so a change can shorten no high phase; this trades a small delay for a
  // clean pin. The pin itself is the registered copy of the clock sample.
  logic clk_src;
  logic inv_live_q;

  assign clk_src = PIXEL_CLK_DIV_SEL ? PIXEL_CLK_DIV_SRC : PIXEL_CLK_SRC;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      inv_live_q <= 1'b0;
    end else if (!clk_src) begin
      inv_live_q <= cfg_q.pixel_clock_invert;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      OUTPUT_PIXEL_CLOCK <= 1'b0;
    end else begin
      OUTPUT_PIXEL_CLOCK <= clk_src ^ inv_live_q;
    end
  end

  // ---------------------------------------------------------------
  // Static configuration outputs and mode decode
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      CLOCK_PIN_DRIVE_LEVEL        <= DRIVE_MED_HIGH;
      SYNC_PIN_DRIVE_LEVEL         <= DRIVE_MED_HIGH;
      CRYSTAL_FREQUENCY_SELECT     <= XTAL_RESET;
      PRIMARY_MODE_CODE            <= MODE_GRAPHICS;
      VIDEO_STANDARD_CODE          <= VIDEO_STANDARD_CODE_RESET;
      COMPONENT_MODE               <= 1'b0;
      GRAPHICS_MODE                <= 1'b1;
      ROUTE_TO_COMPONENT_PROCESSOR <= 1'b1;
    end else begin
      CLOCK_PIN_DRIVE_LEVEL        <= cfg_q.clock_pin_drive_level;
      SYNC_PIN_DRIVE_LEVEL         <= cfg_q.sync_pin_drive_level;
      CRYSTAL_FREQUENCY_SELECT     <= cfg_q.crystal_frequency_select;
      PRIMARY_MODE_CODE            <= cfg_q.primary_mode_code;
      VIDEO_STANDARD_CODE          <= cfg_q.video_standard_code;
      COMPONENT_MODE               <= cfg_q.primary_mode_code == MODE_COMPONENT;
      GRAPHICS_MODE                <= cfg_q.primary_mode_code == MODE_GRAPHICS;
      ROUTE_TO_COMPONENT_PROCESSOR <= (cfg_q.primary_mode_code == MODE_COMPONENT) ||
                                      (cfg_q.primary_mode_code == MODE_GRAPHICS);
    end
  end

  // ---------------------------------------------------------------
  // Synthesizer lock supervision
  // ---------------------------------------------------------------
  // The analog loops sit outside; here their lock flags are qualified and
  // a late flag is raised if lock misses its window.
  logic [CTR_W-1:0] vid_cnt_q;
  logic [CTR_W-1:0] aud_cnt_q;
  logic             aud_wait_q;

  always_ff @(posedge CLK) begin
    if (SYS_RST || VIDEO_FRAME_START || VIDEO_PLL_LOCKED_RAW) begin
      vid_cnt_q <= '0;
    end else if (vid_cnt_q != CTR_W'(FRAME_CYCLES)) begin
      vid_cnt_q <= vid_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      VIDEO_LOCKED    <= 1'b0;
      VIDEO_LOCK_LATE <= 1'b0;
    end else begin
      VIDEO_LOCKED    <= VIDEO_PLL_LOCKED_RAW;
      VIDEO_LOCK_LATE <= !VIDEO_PLL_LOCKED_RAW && (vid_cnt_q == CTR_W'(FRAME_CYCLES));
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      aud_wait_q <= 1'b0;
      aud_cnt_q  <= '0;
    end else if (AUDIO_REGEN_PKT && !AUDIO_PLL_LOCKED_RAW) begin
      aud_wait_q <= 1'b1;
      aud_cnt_q  <= '0;
    end else if (AUDIO_PLL_LOCKED_RAW) begin
      aud_wait_q <= 1'b0;
      aud_cnt_q  <= '0;
    end else if (aud_wait_q && aud_cnt_q != CTR_W'(AUDIO_LOCK_LIMIT)) begin
      aud_cnt_q  <= aud_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      AUDIO_LOCKED    <= 1'b0;
      AUDIO_LOCK_LATE <= 1'b0;
    end else begin
      AUDIO_LOCKED    <= AUDIO_PLL_LOCKED_RAW;
      // A lock that arrives on the expiry edge is not late
      AUDIO_LOCK_LATE <= aud_wait_q && !AUDIO_PLL_LOCKED_RAW && (aud_cnt_q == CTR_W'(AUDIO_LOCK_LIMIT));
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_hs_pol;
    @(posedge CLK) disable iff (SYS_RST)
      1 |=> HORIZONTAL_SYNC_OUT == ($past(TIMING_IN.hsync) ^ ~$past(cfg_q.hsync_polarity));
  endproperty
  a_hs_pol: assert property (p_hs_pol) else $error("hsync polarity wrong");

  property p_vert_sel;
    @(posedge CLK) disable iff (SYS_RST)
      cfg_q.vertical_pin_source_select && !cfg_q.vsync_polarity |=> VERTICAL_FIELD_PIN == !$past(TIMING_IN.vsync);
  endproperty
  a_vert_sel: assert property (p_vert_sel) else $error("vertical pin source wrong");

  property p_vert_pol;
    @(posedge CLK) disable iff (SYS_RST)
      !cfg_q.vertical_pin_source_select && cfg_q.vsync_polarity |=> VERTICAL_FIELD_PIN == $past(TIMING_IN.field);
  endproperty
  a_vert_pol: assert property (p_vert_pol) else $error("vertical pin polarity wrong");

  property p_en_sel;
    @(posedge CLK) disable iff (SYS_RST)
      cfg_q.field_on_enable |=> DATA_ENABLE_OUT == ($past(TIMING_IN.field) ^ $past(cfg_q.field_enable_polarity));
  endproperty
  a_en_sel: assert property (p_en_sel) else $error("enable pin source wrong");

  property p_en_pol;
    @(posedge CLK) disable iff (SYS_RST)
      !cfg_q.field_on_enable && cfg_q.field_enable_polarity |=> DATA_ENABLE_OUT == !$past(TIMING_IN.data_enable);
  endproperty
  a_en_pol: assert property (p_en_pol) else $error("enable polarity wrong");

  property p_main_reset;
    @(posedge CLK) disable iff (SYS_RST)
      main_reset_wr |=> cfg_q == CFG_RESET ##1 SYNC_PIN_DRIVE_LEVEL == DRIVE_MED_HIGH;
  endproperty
  a_main_reset: assert property (p_main_reset) else $error("main reset not applied");

  property p_drive_wr;
    @(posedge CLK) disable iff (SYS_RST)
      REG_WR && REG_ADDR == OUTPUT_DRIVE_STRENGTH_ADDR |=> ##1 CLOCK_PIN_DRIVE_LEVEL == $past(REG_WDATA[3:2], 2);
  endproperty
  a_drive_wr: assert property (p_drive_wr) else $error("clock drive level not updated");

  property p_mode_dec;
    @(posedge CLK) disable iff (SYS_RST)
      cfg_q.primary_mode_code == MODE_COMPONENT |=> COMPONENT_MODE && !GRAPHICS_MODE && ROUTE_TO_COMPONENT_PROCESSOR;
  endproperty
  a_mode_dec: assert property (p_mode_dec) else $error("mode decode wrong");

  property p_clk_inv;
    @(posedge CLK) disable iff (SYS_RST)
      !clk_src && cfg_q.pixel_clock_invert |=> ##1 OUTPUT_PIXEL_CLOCK == !$past(clk_src);
  endproperty
  a_clk_inv: assert property (p_clk_inv) else $error("pixel clock inversion wrong");

  property p_aud_late;
    @(posedge CLK) disable iff (SYS_RST)
      AUDIO_LOCK_LATE |-> $past(aud_wait_q) && !$past(AUDIO_PLL_LOCKED_RAW);
  endproperty
  a_aud_late: assert property (p_aud_late) else $error("audio late flag without wait");

endmodule
`default_nettype wire

// ---- test/pixel_sink_model.sv ----
// Downstream video logic model that samples the sync pins on the output pixel clock
`timescale 1ns/1ns
`default_nettype none
module pixel_sink_model (
  input  wire logic       pixel_clk,
  input  wire logic       hsync,
  input  wire logic       vpin,
  input  wire logic       enable,
  input  wire logic       clear,
  output var  int         edges,
  output var  logic [2:0] last_sync
);
  // ------------------------------------------------------------
  // Capture
  // ------------------------------------------------------------
  // A receiver latches on its own clock; a zero count means the pin never toggled
  always @(posedge pixel_clk or posedge clear) begin
    if (clear) begin
      edges     <= 0;
      last_sync <= 3'h0;
    end else begin
      edges     <= edges + 1;
      last_sync <= {hsync, vpin, enable};
    end
  end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the video output sync and configuration block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import vid_out_pkg::*;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int LOCK_LIM  = 20;
  localparam int FRAME_LEN = 30;
  logic        clk, sys_rst, reg_wr, reg_rd, pclk_src, pclk_div_sel, pclk_div_src;
  logic        vlock_raw, apkt, alock_raw, frame_start, hs_out, vf_pin, de_out, pclk_out;
  logic        comp_mode, gfx_mode, route_cp, vlocked, alocked, vlate, alate, prev_p, prev_v;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [1:0]  clk_drv, sync_drv, xtal;
  logic [3:0]  mode;
  logic [5:0]  std;
  logic [2:0]  last_sync;
  timing_t     timing_in, prev_t;
  int          num_errors, checked, edges;
  logic [31:0] seed;
  logic [7:0]  sh  [7];
  logic [7:0]  adr [7] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h14, 8'hFF};
  logic [7:0]  msk [7] = '{8'h3F, 8'h0F, 8'h06, 8'h10, 8'h8F, 8'h0F, 8'h00};
  logic [7:0]  rst [7] = '{8'h02, 8'h06, 8'h02, 8'h00, 8'h80, 8'h0A, 8'h00};

  video_output_sync_config #(.AUDIO_LOCK_LIMIT(LOCK_LIM), .FRAME_CYCLES(FRAME_LEN), .CTR_W(24)) i_dut (
    .CLK(clk), .SYS_RST(sys_rst), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .TIMING_IN(timing_in), .PIXEL_CLK_SRC(pclk_src),
    .PIXEL_CLK_DIV_SEL(pclk_div_sel), .PIXEL_CLK_DIV_SRC(pclk_div_src), .VIDEO_PLL_LOCKED_RAW(vlock_raw),
    .AUDIO_REGEN_PKT(apkt), .AUDIO_PLL_LOCKED_RAW(alock_raw), .VIDEO_FRAME_START(frame_start),
    .HORIZONTAL_SYNC_OUT(hs_out), .VERTICAL_FIELD_PIN(vf_pin), .DATA_ENABLE_OUT(de_out),
    .OUTPUT_PIXEL_CLOCK(pclk_out), .CLOCK_PIN_DRIVE_LEVEL(clk_drv), .SYNC_PIN_DRIVE_LEVEL(sync_drv),
    .CRYSTAL_FREQUENCY_SELECT(xtal), .PRIMARY_MODE_CODE(mode), .VIDEO_STANDARD_CODE(std),
    .COMPONENT_MODE(comp_mode), .GRAPHICS_MODE(gfx_mode), .ROUTE_TO_COMPONENT_PROCESSOR(route_cp),
    .VIDEO_LOCKED(vlocked), .AUDIO_LOCKED(alocked), .VIDEO_LOCK_LATE(vlate), .AUDIO_LOCK_LATE(alate));

  pixel_sink_model i_sink (.pixel_clk(pclk_out), .hsync(hs_out), .vpin(vf_pin), .enable(de_out),
    .clear(sys_rst), .edges(edges), .last_sync(last_sync));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [2:0] exp_sync(input logic [7:0] r6, input logic [7:0] r5, input timing_t t);
    logic hs, vp, de;
    hs = t.hsync ^ ~r6[HS_POL_BIT];
    vp = (r6[VERT_SRC_BIT] ? t.vsync : t.field) ^ ~r6[VS_POL_BIT];
    de = (r5[FIELD_ON_EN_BIT] ? t.field : t.data_enable) ^ r6[FE_POL_BIT];
    return {hs, vp, de};
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (num_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  task automatic write_all();
    for (int i = 0; i < 6; i++) begin
      wr(adr[i], sh[i]);
    end
    repeat (2) @(negedge clk);
  endtask

  // Field copies, mode decode and masked readback of every register
  task automatic check_ports();
    logic [7:0] d;
    check("video standard", {2'h0, std}, sh[0] & 8'h3F);
    check("primary mode", {4'h0, mode}, sh[1] & 8'h0F);
    check("crystal", {6'h0, xtal}, (sh[2] >> 1) & 8'h03);
    check("clock drive", {6'h0, clk_drv}, (sh[5] >> 2) & 8'h03);
    check("sync drive", {6'h0, sync_drv}, sh[5] & 8'h03);
    check("component", {7'h0, comp_mode}, {7'h0, sh[1][3:0] == MODE_COMPONENT});
    check("graphics", {7'h0, gfx_mode}, {7'h0, sh[1][3:0] == MODE_GRAPHICS});
    check("route", {7'h0, route_cp}, {7'h0, sh[1][3:0] inside {MODE_COMPONENT, MODE_GRAPHICS}});
    for (int i = 0; i < 7; i++) begin
      rd(adr[i], d);
      check("readback", d, sh[i] & msk[i]);
    end
  endtask

  // ------------------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // The whole run needs about a thousand cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    logic [7:0] d;
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata, timing_in} = {2'b10, 1'b0, 20'h0};
    {pclk_src, pclk_div_sel, pclk_div_src, vlock_raw, apkt, alock_raw, frame_start} = 7'h00;
    seed = 32'd29463;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++) sh[i] = rst[i];
    @(negedge clk);
    check_ports();
    rd(8'h33, d);
    check("unmapped read", d, 8'h00);
    // Every drive, crystal and mode code, with random standards and reserved bits set
    for (int c = 0; c < 16; c++) begin
      seed = xs(seed);
      sh[0] = seed[7:0];
      sh[1] = {seed[11:8], c[3:0]};
      sh[2] = {seed[15:11], c[1:0], c[2]};
      sh[5] = {seed[19:16], c[3:0]};
      write_all();
      check_ports();
    end
    sh[1] = 8'h06;
    sh[0] = 8'h02;
    write_all();
    check_ports();
    // Steering and polarity: sync register all zeros, then both registers all ones, then random settings
    for (int r = 0; r < 8; r++) begin
      seed = xs(seed);
      sh[4] = (r == 0) ? 8'h00 : (r == 1) ? 8'hFF : seed[7:0];
      sh[3] = (r == 1) ? 8'hFF : seed[15:8];
      wr(adr[3], sh[3]);
      wr(adr[4], sh[4]);
      pclk_src     <= 1'b0;
      pclk_div_src <= 1'b0;
      repeat (4) @(posedge clk);
      for (int k = 0; k < 40; k++) begin
        @(posedge clk);
        prev_t = timing_in;
        prev_p = pclk_div_sel ? pclk_div_src : pclk_src;
        prev_v = vlock_raw;
        seed = xs(seed);
        timing_in <= seed[3:0];
        {pclk_src, pclk_div_sel, pclk_div_src, vlock_raw} <= seed[7:4];
        @(negedge clk);
        check("sync pins", {5'h0, hs_out, vf_pin, de_out}, {5'h0, exp_sync(sh[4], sh[3], prev_t)});
        check("pixel clock", {7'h0, pclk_out}, {7'h0, prev_p ^ sh[4][CLK_INV_BIT]});
        check("video lock", {7'h0, vlocked}, {7'h0, prev_v});
      end
    end
    check("pixel clock edges", {7'h0, edges != 0}, 8'h01);
    // Lock supervision: frame start and packet without lock, then lock arrives
    @(posedge clk);
    {vlock_raw, alock_raw, frame_start, apkt} <= 4'h3;
    @(posedge clk);
    {frame_start, apkt} <= 2'h0;
    repeat (10) @(negedge clk);
    check("video late early", {7'h0, vlate}, 8'h00);
    check("audio late early", {7'h0, alate}, 8'h00);
    repeat (35) @(negedge clk);
    check("video late", {7'h0, vlate}, 8'h01);
    check("audio late", {7'h0, alate}, 8'h01);
    @(posedge clk);
    {vlock_raw, alock_raw} <= 2'h3;
    repeat (3) @(negedge clk);
    check("video late cleared", {7'h0, vlate}, 8'h00);
    check("audio locked", {7'h0, alocked}, 8'h01);
    check("audio late cleared", {7'h0, alate}, 8'h00);
    // Main reset after random contents
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      sh[i] = seed[7:0];
    end
    write_all();
    timing_in <= '0;
    wr(MAIN_RESET_ADDR, 8'h80);
    for (int i = 0; i < 7; i++) sh[i] = rst[i];
    repeat (2) @(negedge clk);
    check_ports();
    check("sync after reset", {5'h0, hs_out, vf_pin, de_out}, {5'h0, exp_sync(sh[4], sh[3], '0)});
    // Pins stand still while the sink sees one clean rising pixel clock
    {pclk_src, pclk_div_sel} <= 2'h0;
    repeat (2) @(posedge clk);
    pclk_src <= 1'b1;
    repeat (3) @(negedge clk);
    check("sink capture", {5'h0, last_sync}, {5'h0, exp_sync(sh[4], sh[3], '0)});
    check("pixel clock high", {7'h0, pclk_out}, 8'h01);
    tally_and_finish();
  end
endmodule
`default_nettype wire
